/* File: rtl/aifc_fault_codes.sv */
// Fault diagnosis and fault code latch of a four-channel safety analog input.
// Assumes all detector inputs are synchronous levels on mclk, except the
// echo and sequence strobes, which are one-cycle pulses.
`default_nettype none

module aifc_fault_codes (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Per-channel measurement and range
    input wire logic [aifc_pkg::NUM_CH-1:0][aifc_pkg::VAL_W-1:0] chanValue,
    input wire logic [aifc_pkg::NUM_CH-1:0][aifc_pkg::VAL_W-1:0] rangeHigh,
    input wire logic [aifc_pkg::NUM_CH-1:0][aifc_pkg::VAL_W-1:0] rangeLow,
    input wire logic [aifc_pkg::VAL_W-1:0] pairTolerance,
    input wire logic [1:0] dualMode,
    input wire logic [1:0] tachMode,
    input wire logic [aifc_pkg::NUM_CH-1:0] chanLow,
    input wire logic [aifc_pkg::NUM_CH-1:0] measDisagree,
    input wire logic [aifc_pkg::NUM_CH-1:0][7:0] cfgConvA,
    input wire logic [aifc_pkg::NUM_CH-1:0][7:0] cfgConvB,
    // Supply monitors
    input wire logic supplyOverCur,
    input wire logic supplyUnderCur,
    input wire logic logicSupplyLow,
    input wire logic logicSupplyHigh,
    input wire logic runWindowFault,
    input wire logic startWindowFault,
    input wire logic fieldPowerBad,
    input wire logic partnerRailFault,
    // Converter self-tests
    input wire logic cpuDiagFail,
    input wire logic progMemFail,
    input wire logic workMemFail,
    input wire logic nvMemOverCur,
    input wire logic testPatternFail,
    input wire logic watchdogExpired,
    input wire logic syncLost,
    input wire logic clockMissing,
    // Internal serial link
    input wire logic serPatternFault,
    input wire logic serial_transmit_bit_fault,
    input wire logic seqValid,
    input wire logic [7:0] seqNum,
    // Multiplexer pulse test
    output logic muxTestStart,
    output logic [1:0] muxTestChannel,
    input wire logic muxEchoValid,
    input wire logic [1:0] muxEchoChannel,
    // Attribute read service
    input wire logic reqValid,
    input wire logic [7:0] reqService,
    input wire logic [15:0] reqInstance,
    output logic rspValid,
    output logic rspOk,
    output logic [aifc_pkg::CODE_W-1:0] rspCode,
    // Status
    output logic timingFlag
);
    import aifc_pkg::*;

    // ==========================================================
    // Declarations
    aifc_state_t cur_ff; // Registered state
    aifc_state_t nxt_cur; // Next state
    logic [NUM_CH-1:0][NUM_CAUSES-1:0] ownCause; // Causes before partner term
    logic [NUM_CH-1:0][CODE_W-1:0] selCode; // Selected code per channel
    logic [NUM_CH-1:0] ownFault; // Channel has a cause of its own
    logic [NUM_CH-1:0] readHit; // Channel read this cycle
    logic [2:0] timingCount; // Number of timing causes active
    logic anyTiming; // Some timing cause active
    logic [15:0] reqIndex; // Instance minus first instance
    logic reqGood; // Read request valid for a channel

    // ==========================================================
    // Read decode
    assign reqIndex = reqInstance - INST_FIRST;
    assign reqGood = reqValid && (reqService == SVC_GET_ATTR) &&
        (reqInstance >= INST_FIRST) && (reqIndex < 16'(NUM_CH));

    // ==========================================================
    // Timing causes, ORed for the combined flag and counted for code 102
    assign anyTiming = watchdogExpired | syncLost | clockMissing;
    assign timingCount = 3'(watchdogExpired) + 3'(syncLost) + 3'(clockMissing);

    // ==========================================================
    // Per-channel cause gathering and selection
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gen_ch
            localparam int PARTNER = g ^ 1; // Other channel of the pair
            localparam int PAIR = g / 2; // Pair index
            aifc_sel_if selIf ();
            logic [VAL_W-1:0] diff; // Absolute pair difference
            logic multiTiming; // Several timing causes at once

            // Pair difference, larger minus smaller
            assign diff = (chanValue[g] >= chanValue[PARTNER]) ?
                chanValue[g] - chanValue[PARTNER] :
                chanValue[PARTNER] - chanValue[g];
            assign multiTiming = timingCount > 3'h1;

            // Causes seen by this channel, partner term left out
            always_comb begin
                ownCause[g] = '0;
                ownCause[g][C_OVER] = chanValue[g] > rangeHigh[g];
                ownCause[g][C_UNDER] = chanValue[g] < rangeLow[g];
                ownCause[g][C_DISC] = dualMode[PAIR] && (diff > pairTolerance);
                ownCause[g][C_SUP_OVER] = supplyOverCur;
                ownCause[g][C_SUP_UNDER] = supplyUnderCur;
                ownCause[g][C_TIMING] = multiTiming;
                ownCause[g][C_V33_LO] = logicSupplyLow;
                ownCause[g][C_V33_HI] = logicSupplyHigh;
                ownCause[g][C_CPU] = cpuDiagFail;
                ownCause[g][C_FLASH] = progMemFail;
                ownCause[g][C_RAM] = workMemFail;
                ownCause[g][C_SINGLE] = measDisagree[g];
                ownCause[g][C_TACH] = tachMode[PAIR] && chanLow[g] && chanLow[PARTNER];
                ownCause[g][C_FLASH_EN] = nvMemOverCur;
                ownCause[g][C_PATTERN] = serPatternFault;
                ownCause[g][C_MUX] = cur_ff.muxFail[g];
                ownCause[g][C_WDOG] = watchdogExpired && !multiTiming;
                ownCause[g][C_SYNC] = syncLost && !multiTiming;
                ownCause[g][C_CLK] = clockMissing && !multiTiming;
                ownCause[g][C_SER_TX] = serial_transmit_bit_fault;
                ownCause[g][C_ADC] = testPatternFail;
                ownCause[g][C_NBR] = partnerRailFault;
                ownCause[g][C_CFG] = cfgConvA[g] != cfgConvB[g];
                ownCause[g][C_SEQ] = cur_ff.seqFail;
                ownCause[g][C_RUN_WIN] = runWindowFault;
                ownCause[g][C_FIELD] = fieldPowerBad;
                ownCause[g][C_START_WIN] = startWindowFault;
            end

            assign ownFault[g] = |ownCause[g];

            // Partner term added from the partner's own causes only
            always_comb begin
                selIf.causes = ownCause[g];
                selIf.causes[C_PARTNER] = dualMode[PAIR] && ownFault[PARTNER];
            end

            assign selCode[g] = selIf.code;
            assign readHit[g] = reqGood && (reqIndex[1:0] == 2'(g));

            // Priority selection for this channel
            aifc_code_select u_sel (
                .sel(selIf.sel)
            );
        end
    endgenerate

    // ==========================================================
    // Next-state logic
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.muxStart = 1'b0;
        nxt_cur.muxFail = '0;
        nxt_cur.seqFail = 1'b0;
        nxt_cur.rspValid = 1'b0;
        nxt_cur.timingFlag = anyTiming;

        // Test period divider
        if (cur_ff.divCnt == DIV_W'(MUX_TEST_PERIOD_CYC - 1)) begin
            nxt_cur.divCnt = '0;
        end else begin
            nxt_cur.divCnt = cur_ff.divCnt + 1'b1;
        end

        // Multiplexer pulse test sequencer
        unique case (cur_ff.st)
            MT_IDLE: begin
                // Start a test at each period tick
                if (cur_ff.divCnt == '0) begin
                    nxt_cur.st = MT_PULSE;
                    nxt_cur.muxStart = 1'b1;
                end
            end
            MT_PULSE: begin
                // Pulse lasts one cycle, then wait for the echo
                nxt_cur.st = MT_WAIT;
                nxt_cur.waitCnt = '0;
            end
            MT_WAIT: begin
                if (muxEchoValid) begin
                    // Wrong echo marks the channel under test
                    if (muxEchoChannel != cur_ff.testCh) begin
                        nxt_cur.muxFail[cur_ff.testCh] = 1'b1;
                    end
                    nxt_cur.st = MT_IDLE;
                    nxt_cur.testCh = cur_ff.testCh + 1'b1;
                end else if (cur_ff.waitCnt == WAIT_W'(MUX_ECHO_TIMEOUT_CYC - 1)) begin
                    // No echo counts as a wrong selection
                    nxt_cur.muxFail[cur_ff.testCh] = 1'b1;
                    nxt_cur.st = MT_IDLE;
                    nxt_cur.testCh = cur_ff.testCh + 1'b1;
                end else begin
                    nxt_cur.waitCnt = cur_ff.waitCnt + 1'b1;
                end
            end
            default: nxt_cur.st = MT_IDLE;
        endcase

        // Sequence number check, resynchronise on a miss
        if (seqValid) begin
            nxt_cur.seqFail = seqNum != cur_ff.seqExp;
            nxt_cur.seqExp = seqNum + 1'b1;
        end

        // Code latch per channel, a new cause wins over a read
        for (int c = 0; c < NUM_CH; c++) begin
            if (selCode[c] != CODE_NO_ERR) begin
                nxt_cur.code[c] = selCode[c];
            end else if (readHit[c]) begin
                nxt_cur.code[c] = CODE_NO_ERR;
            end
        end

        // Answer to a read request, one cycle later
        if (reqValid) begin
            nxt_cur.rspValid = 1'b1;
            nxt_cur.rspOk = reqGood;
            nxt_cur.rspCode = reqGood ? cur_ff.code[reqIndex[1:0]] : '0;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff.st <= MT_IDLE;
            cur_ff.divCnt <= '0;
            cur_ff.waitCnt <= '0;
            cur_ff.testCh <= '0;
            cur_ff.muxStart <= 1'b0;
            cur_ff.muxFail <= '0;
            cur_ff.seqExp <= SEQ_RESET;
            cur_ff.seqFail <= 1'b0;
            cur_ff.timingFlag <= 1'b0;
            cur_ff.rspValid <= 1'b0;
            cur_ff.rspOk <= 1'b0;
            cur_ff.rspCode <= '0;
            cur_ff.code <= {NUM_CH{CODE_RESET}};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ==========================================================
    // Outputs straight from the register
    assign muxTestStart = cur_ff.muxStart;
    assign muxTestChannel = cur_ff.testCh;
    assign rspValid = cur_ff.rspValid;
    assign rspOk = cur_ff.rspOk;
    assign rspCode = cur_ff.rspCode;
    assign timingFlag = cur_ff.timingFlag;

endmodule

`default_nettype wire

/* File: rtl/aifc_pkg.sv */
// Constants, cause indices and state types of the analog input fault coder.
// Assumes every module of the block imports it whole.
//
// Functional notes
// - Above range gives 2, below gives 3.
// - Pair difference beyond tolerance gives 5.
// - Faulted partner channel gives 6.
// - Supply overcurrent 100, undercurrent 101.
// - Two or more converter timing causes at once give 102.
// - Logic supply low 103, high 104.
// - Processor self-diagnostic failure gives 105.
// - Program memory 106, working memory 107.
// - Redundant single-channel measurements disagree: 108.
// - Tachometer pair both low gives 109.
// - Nonvolatile memory overcurrent gives 111.
// - Serial pattern 112, transmit bit 117.
// - Multiplexer pulse test wrong channel: 113.
// - Converter watchdog expiry gives 114.
// - Conversion synchronisation loss gives 115.
// - Missing converter clock edge gives 116.
// - Converter test-pattern failure gives 118.
// - Partner 1.8 V rail fault gives 119.
// - Converter configuration mismatch gives 120.
// - Serial sequence number mismatch gives 121.
// - Runtime window 122, startup self-test 126.
// - Field 24 V power out of limits: 125.
// - Read service 0E returns channel code.
`default_nettype none

package aifc_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_MHZ = 40; // Rate of mclk
    localparam int MUX_TEST_PERIOD_US = 100; // Spacing of multiplexer pulse tests
    localparam int MUX_TEST_PERIOD_CYC = MUX_TEST_PERIOD_US * CLK_MHZ;
    localparam int MUX_ECHO_TIMEOUT_NS = 1000; // Longest wait for a test echo
    localparam int MUX_ECHO_TIMEOUT_CYC = (MUX_ECHO_TIMEOUT_NS * CLK_MHZ) / 1000;

    // ==========================================================
    // Sizes
    localparam int NUM_CH = 4; // Input channels
    localparam int VAL_W = 16; // Measured value width
    localparam int CODE_W = 8; // Fault code width
    localparam int DIV_W = 12; // Test period counter width
    localparam int WAIT_W = 6; // Echo timeout counter width

    // ==========================================================
    // Read service
    localparam logic [7:0] SVC_GET_ATTR = 8'h0E; // Attribute read service code
    localparam logic [15:0] INST_FIRST = 16'h0001; // First channel instance
    localparam logic [CODE_W-1:0] CODE_NO_ERR = 8'h01; // No fault present
    localparam logic [CODE_W-1:0] CODE_RESET = 8'h01; // Code register reset value
    localparam logic [7:0] SEQ_RESET = 8'h00; // First expected sequence number

    // ==========================================================
    // Cause indices, lowest index has the highest priority
    typedef enum int {
        C_OVER, C_UNDER, C_DISC, C_PARTNER, C_SUP_OVER, C_SUP_UNDER, C_TIMING,
        C_V33_LO, C_V33_HI, C_CPU, C_FLASH, C_RAM, C_SINGLE, C_TACH, C_FLASH_EN,
        C_PATTERN, C_MUX, C_WDOG, C_SYNC, C_CLK, C_SER_TX, C_ADC, C_NBR,
        C_CFG, C_SEQ, C_RUN_WIN, C_FIELD, C_START_WIN, NUM_CAUSES
    } aifc_cause_t;

    // Reported code of each cause, in cause order
    localparam logic [CODE_W-1:0] CAUSE_CODE [NUM_CAUSES] = '{
        8'h02, 8'h03, 8'h05, 8'h06, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h69,
        8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6F, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74,
        8'h75, 8'h76, 8'h77, 8'h78, 8'h79, 8'h7A, 8'h7D, 8'h7E
    };

    // ==========================================================
    // Multiplexer test sequencer and top-level state
    typedef enum logic [1:0] {
        MT_IDLE, MT_PULSE, MT_WAIT
    } aifc_mstate_t;

    typedef struct packed {
        aifc_mstate_t st; // Test sequencer state
        logic [DIV_W-1:0] divCnt; // Test period divider
        logic [WAIT_W-1:0] waitCnt; // Echo wait counter
        logic [1:0] testCh; // Channel under test
        logic muxStart; // Test pulse to the multiplexer
        logic [NUM_CH-1:0] muxFail; // Wrong channel pulse per channel
        logic [7:0] seqExp; // Next expected sequence number
        logic seqFail; // Sequence mismatch pulse
        logic timingFlag; // Combined converter timing flag
        logic rspValid; // Answer strobe
        logic rspOk; // Answer accepted
        logic [CODE_W-1:0] rspCode; // Answer code
        logic [NUM_CH-1:0][CODE_W-1:0] code; // Latched code per channel
    } aifc_state_t;

endpackage

`default_nettype wire

/* File: rtl/aifc_sel_if.sv */
// Carrier between the fault coder and its per-channel code selector.
// Assumes one instance per channel.
`default_nettype none

interface aifc_sel_if;
    import aifc_pkg::*;
    logic [NUM_CAUSES-1:0] causes; // Active causes of one channel
    logic [CODE_W-1:0] code; // Selected code
    modport src (output causes, input code);
    modport sel (input causes, output code);
endinterface

`default_nettype wire

/* File: rtl/aifc_code_select.sv */
// Priority selector from a channel's cause vector to one fault code.
// Assumes the causes are already combined for that channel.
`default_nettype none

module aifc_code_select (
    // Cause vector in, code out
    aifc_sel_if.sel sel
);
    import aifc_pkg::*;

    // ==========================================================
    // Priority encoder, lowest index wins
    always_comb begin
        sel.code = CODE_NO_ERR;
        for (int i = NUM_CAUSES - 1; i >= 0; i--) begin
            // Later iterations have higher priority
            if (sel.causes[i]) begin
                sel.code = CAUSE_CODE[i];
            end
        end
    end

endmodule

`default_nettype wire

/* File: verification/aifc_fault_codes_asserts.sv */
// Checker of the fault coder's read service, timing flag and test pulse.
// Assumes it is bound into aifc_fault_codes and sees its ports only.
`default_nettype none

module aifc_fault_codes_asserts (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Read service
    input wire logic reqValid,
    input wire logic [7:0] reqService,
    input wire logic [15:0] reqInstance,
    input wire logic rspValid,
    input wire logic rspOk,
    input wire logic [aifc_pkg::CODE_W-1:0] rspCode,
    // Converter timing and test pulse
    input wire logic watchdogExpired,
    input wire logic syncLost,
    input wire logic clockMissing,
    input wire logic timingFlag,
    input wire logic muxTestStart
);
    timeunit 1ns;
    timeprecision 1ps;
    import aifc_pkg::*;
    // ==========
    // Helper logic
    logic anyTime; // Any timing input high
    logic goodReq; // Known service and instance
    logic [12:0] gap_ff; // Cycles since last test pulse
    logic seen_ff; // First pulse has passed
    assign anyTime = watchdogExpired | syncLost | clockMissing;
    assign goodReq = reqService == SVC_GET_ATTR && reqInstance > 16'h0000
        && reqInstance < 16'h0005;
    // Counts the spacing of test pulses
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gap_ff <= 13'h0000;
            seen_ff <= 1'b0;
        end else begin
            gap_ff <= muxTestStart ? 13'h0000 : gap_ff + 13'h0001;
            seen_ff <= seen_ff | muxTestStart;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ==========
    // Assertions
    AST_RSP_NEXT: assert property (reqValid |=> rspValid)
        else $error("no answer after request");
    AST_RSP_NONE: assert property (!reqValid |=> !rspValid)
        else $error("answer without request");
    AST_RSP_GOOD: assert property (reqValid && goodReq |=> rspOk)
        else $error("good request refused");
    AST_RSP_REFUSE: assert property (reqValid && !goodReq |=> !rspOk && rspCode == 8'h00)
        else $error("bad request accepted");
    AST_RSP_HOLD: assert property (!rspValid |-> $stable(rspCode) && $stable(rspOk))
        else $error("answer changed without strobe");
    AST_TIMING_ON: assert property (anyTime |=> timingFlag)
        else $error("timing flag missing");
    AST_TIMING_OFF: assert property (!anyTime |=> !timingFlag)
        else $error("timing flag without cause");
    AST_MUX_PULSE: assert property (muxTestStart |=> !muxTestStart [*8])
        else $error("test pulse too long");
    AST_MUX_PERIOD: assert property (muxTestStart && seen_ff |-> gap_ff == MUX_TEST_PERIOD_CYC - 1)
        else $error("test pulse spacing wrong");
    // Main scenarios seen
    cover property (rspValid && rspOk && rspCode == 8'h71);
    cover property (rspValid && !rspOk);
    cover property (timingFlag && rspValid);
endmodule

bind aifc_fault_codes aifc_fault_codes_asserts chk_u (
    .mclk(mclk), .rst_n(rst_n), .reqValid(reqValid), .reqService(reqService),
    .reqInstance(reqInstance), .rspValid(rspValid), .rspOk(rspOk), .rspCode(rspCode),
    .watchdogExpired(watchdogExpired), .syncLost(syncLost), .clockMissing(clockMissing),
    .timingFlag(timingFlag), .muxTestStart(muxTestStart)
);

`default_nettype wire

/* File: verification/aifc_ctl_model.sv */
// Safety controller model that reads channel fault codes.
// Assumes the coder answers exactly one cycle after taking a request.
`default_nettype none

module aifc_ctl_model (
    // Clock
    input wire logic mclk,
    // Request
    output logic reqValid,
    output logic [7:0] reqService,
    output logic [15:0] reqInstance,
    // Answer
    input wire logic rspValid,
    input wire logic rspOk,
    input wire logic [aifc_pkg::CODE_W-1:0] rspCode
);
    timeunit 1ns;
    timeprecision 1ps;
    import aifc_pkg::*;
    initial begin
        reqValid = 1'b0;
        reqService = 8'h00;
        reqInstance = 16'h0000;
    end
    // One attribute read; released fields show inverted values
    task automatic get(input logic [7:0] svc, input logic [15:0] inst,
            output logic ok, output logic [CODE_W-1:0] code);
        @(posedge mclk);
        reqValid <= 1'b1;
        reqService <= svc;
        reqInstance <= inst;
        @(posedge mclk);
        reqValid <= 1'b0;
        reqService <= ~svc;
        reqInstance <= ~inst;
        #1;
        ok = rspValid ? rspOk : 1'bx;
        code = rspCode;
    endtask
endmodule

`default_nettype wire

/* File: verification/aifc_fault_codes_tb.sv */
// Self-checking bench of the analog input fault coder.
// Assumes the controller model and the bound checker are compiled with it.
`default_nettype none

module aifc_fault_codes_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import aifc_pkg::*;
    // ==========
    // Stimulus and observation
    logic mclk, rst_n, seqValid, muxEchoValid, wrongEcho, muxTestStart;
    logic reqValid, rspValid, rspOk, timingFlag;
    logic [NUM_CH-1:0][VAL_W-1:0] chanValue, rangeHigh, rangeLow;
    logic [VAL_W-1:0] pairTolerance;
    logic [1:0] dualMode, tachMode, muxEchoChannel, muxTestChannel;
    logic [NUM_CH-1:0] chanLow, measDisagree;
    logic [NUM_CH-1:0][7:0] cfgConvA, cfgConvB;
    logic [17:0] flg; // Module-wide fault inputs
    logic [7:0] seqNum, reqService, svcUse;
    logic [15:0] reqInstance;
    logic [CODE_W-1:0] rspCode;
    int fail_count, checks_done, cycles;
    // Expected code per bit of flg
    logic [7:0] wideCode [18] = '{8'h64, 8'h65, 8'h67, 8'h68, 8'h7A, 8'h7E, 8'h7D, 8'h77,
        8'h69, 8'h6A, 8'h6B, 8'h6F, 8'h76, 8'h72, 8'h73, 8'h74, 8'h70, 8'h75};

    aifc_fault_codes dut_u (.mclk(mclk), .rst_n(rst_n), .chanValue(chanValue),
        .rangeHigh(rangeHigh), .rangeLow(rangeLow), .pairTolerance(pairTolerance),
        .dualMode(dualMode), .tachMode(tachMode), .chanLow(chanLow),
        .measDisagree(measDisagree), .cfgConvA(cfgConvA), .cfgConvB(cfgConvB),
        .supplyOverCur(flg[0]), .supplyUnderCur(flg[1]), .logicSupplyLow(flg[2]),
        .logicSupplyHigh(flg[3]), .runWindowFault(flg[4]), .startWindowFault(flg[5]),
        .fieldPowerBad(flg[6]), .partnerRailFault(flg[7]), .cpuDiagFail(flg[8]),
        .progMemFail(flg[9]), .workMemFail(flg[10]), .nvMemOverCur(flg[11]),
        .testPatternFail(flg[12]), .watchdogExpired(flg[13]), .syncLost(flg[14]),
        .clockMissing(flg[15]), .serPatternFault(flg[16]),
        .serial_transmit_bit_fault(flg[17]), .seqValid(seqValid), .seqNum(seqNum),
        .muxTestStart(muxTestStart), .muxTestChannel(muxTestChannel),
        .muxEchoValid(muxEchoValid), .muxEchoChannel(muxEchoChannel),
        .reqValid(reqValid), .reqService(reqService), .reqInstance(reqInstance),
        .rspValid(rspValid), .rspOk(rspOk), .rspCode(rspCode), .timingFlag(timingFlag));
    aifc_ctl_model ctl_u (.mclk(mclk), .reqValid(reqValid), .reqService(reqService),
        .reqInstance(reqInstance), .rspValid(rspValid), .rspOk(rspOk), .rspCode(rspCode));

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Echoes each test pulse; wrongEcho names the next channel instead
    always @(posedge mclk) begin
        muxEchoValid <= muxTestStart;
        muxEchoChannel <= muxTestChannel + 2'(wrongEcho);
    end
    // Hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end
    // ==========
    // Shared tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // Read one channel; a zero code means a refusal is expected
    task automatic rd(input logic [15:0] inst, input logic [7:0] exp);
        logic ok;
        logic [7:0] code;
        ctl_u.get(svcUse, inst, ok, code);
        chk("answer accepted", {7'h00, exp != 8'h00}, {7'h00, ok});
        chk("fault code", exp, code);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic defaults();
        chanValue <= {4{16'h0400}};
        rangeHigh <= {4{16'h0800}};
        rangeLow <= {4{16'h0100}};
        pairTolerance <= 16'h0080;
        dualMode <= 2'b00;
        tachMode <= 2'b00;
        chanLow <= 4'h0;
        measDisagree <= 4'h0;
        cfgConvA <= {4{8'h00}};
        cfgConvB <= {4{8'h00}};
        flg <= 18'h00000;
        seqValid <= 1'b0;
    endtask
    // Back to quiet inputs, then read every latch empty
    task automatic idle();
        logic okDrop;
        logic [7:0] codeDrop;
        @(posedge mclk);
        defaults();
        cyc(3);
        for (int i = 1; i < 5; i++) begin
            ctl_u.get(SVC_GET_ATTR, 16'(i), okDrop, codeDrop);
            rd(16'(i), CODE_NO_ERR);
        end
    endtask
    // ==========
    // Scenarios
    task automatic t_wide();
        logic [17:0] m;
        logic [7:0] e;
        for (int i = 0; i < 20; i++) begin
            m = (i < 18) ? 18'(1 << i) : (i == 18) ? 18'h0A000 : 18'h20001;
            e = (i < 18) ? wideCode[i] : (i == 18) ? 8'h66 : 8'h64;
            @(posedge mclk);
            flg <= m;
            cyc(3);
            rd(16'(i % 4 + 1), e);
            chk("timing flag", {7'h00, |m[15:13]}, {7'h00, timingFlag});
            @(posedge mclk);
            flg <= 18'h00000;
            cyc(3);
            rd(16'(i % 4 + 1), e);
            rd(16'(i % 4 + 1), CODE_NO_ERR);
        end
    endtask
    task automatic t_pair();
        @(posedge mclk);
        chanValue[3] <= 16'h00FF;
        chanValue[2] <= 16'h0801;
        dualMode <= 2'b01;
        chanValue[1] <= 16'h0481;
        cyc(3);
        rd(16'h0003, 8'h02);
        rd(16'h0004, 8'h03);
        rd(16'h0002, 8'h05);
        @(posedge mclk);
        chanValue[1] <= 16'h0480;
        cyc(3);
        rd(16'h0001, 8'h05);
        rd(16'h0001, CODE_NO_ERR);
        @(posedge mclk);
        rangeHigh[0] <= 16'h03FF;
        chanValue[1] <= 16'h0400;
        cyc(3);
        rd(16'h0001, 8'h02);
        rd(16'h0002, 8'h06);
    endtask
    task automatic t_chan();
        @(posedge mclk);
        measDisagree <= 4'b0100;
        tachMode <= 2'b10;
        chanLow <= 4'b1000;
        cfgConvB[1] <= 8'h01;
        cyc(3);
        rd(16'h0003, 8'h6C);
        rd(16'h0004, CODE_NO_ERR);
        rd(16'h0002, 8'h78);
        @(posedge mclk);
        chanLow <= 4'b1100;
        cyc(3);
        rd(16'h0004, 8'h6D);
    endtask
    task automatic t_seq();
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            seqValid <= 1'b1;
            seqNum <= (k == 0) ? 8'h00 : 8'h05;
            @(posedge mclk);
            seqValid <= 1'b0;
            cyc(4);
            rd(16'h0003, (k == 0) ? CODE_NO_ERR : 8'h79);
        end
    endtask
    task automatic t_refuse();
        @(posedge mclk);
        flg <= 18'h00001;
        @(posedge mclk);
        flg <= 18'h00000;
        cyc(3);
        svcUse = 8'h0F;
        rd(16'h0001, 8'h00);
        svcUse = SVC_GET_ATTR;
        rd(16'h0000, 8'h00);
        rd(16'h0005, 8'h00);
        rd(16'h0001, 8'h64);
    endtask
    task automatic t_mux();
        int n;
        logic [1:0] ch;
        n = 0;
        @(posedge mclk);
        wrongEcho <= 1'b1;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (muxTestStart !== 1'b1 && n < 4100);
        ch = muxTestChannel;
        chk("test pulse", 8'h01, {7'h00, muxTestStart});
        cyc(8);
        wrongEcho <= 1'b0;
        rd(16'(ch) + 16'h0001, 8'h71);
    endtask
    // ==========
    // Verdict
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        wrongEcho = 1'b0;
        seqNum = 8'h00;
        svcUse = SVC_GET_ATTR;
        defaults();
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 1; i < 5; i++) begin
            rd(16'(i), CODE_NO_ERR);
        end
        t_wide();
        t_pair();
        idle();
        t_chan();
        idle();
        t_seq();
        idle();
        t_refuse();
        t_mux();
        test_done();
    end
endmodule

`default_nettype wire
